// File: pkg/pfc_pkg.sv
`default_nettype none
package pfc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [31:0] IDX_PA_FUNC    = 32'hFFFFFC80;
   localparam logic [31:0] IDX_PA_DIR     = 32'hFFFFFC82;
   localparam logic [31:0] IDX_PB_FUNC_HI = 32'hFFFFFC88;
   localparam logic [31:0] IDX_PB_DIR     = 32'hFFFFFC8A;
   localparam logic [31:0] IDX_PB_FUNC_LO = 32'hFFFFFC8E;

   // Positions in the one-hot hit vector
   localparam int REG_CNT     = 5;
   localparam int HIT_PA_FUNC = 0;
   localparam int HIT_PA_DIR  = 1;
   localparam int HIT_PB_HI   = 2;
   localparam int HIT_PB_DIR  = 3;
   localparam int HIT_PB_LO   = 4;

   // Values after power-on reset and writable bits
   localparam logic [15:0] PA_FUNC_RST  = 16'h0000;
   localparam logic [15:0] PA_DIR_RST   = 16'h0000;
   localparam logic [15:0] PB_RST       = 16'h0000;
   localparam logic [15:0] PA_FUNC_MASK = 16'h3FFF;
   localparam logic [15:0] PA_DIR_MASK  = 16'h3FF7;
   localparam logic [15:0] PB_MASK      = 16'hFFFF;

   // Pin attributes, one bit per port A pin
   localparam int          PIN_CNT     = 14;
   localparam logic [13:0] PIN_GPIO    = 14'h3FF7;
   localparam logic [13:0] PIN_ALT_OUT = 14'h039A;
   localparam logic [13:0] PIN_ALT_IN  = 14'h3E65;
   localparam logic [13:0] PIN_INV     = 14'h0080;

   // Pin numbers by function
   localparam int PIN_NET_SENSE = 0;
   localparam int PIN_NET_OUT   = 1;
   localparam int PIN_NET_LINK  = 2;
   localparam int PIN_PCLK      = 3;
   localparam int PIN_FT_CMPA   = 4;
   localparam int PIN_FT_CAP    = 5;
   localparam int PIN_FT_CLK    = 6;
   localparam int PIN_WDOG      = 7;
   localparam int PIN_S0_TXDATA = 8;
   localparam int PIN_S0_TXSYNC = 9;
   localparam int PIN_S0_TXCLK  = 10;
   localparam int PIN_S0_RXDATA = 11;
   localparam int PIN_S0_RXSYNC = 12;
   localparam int PIN_S0_RXCLK  = 13;
endpackage
`default_nettype wire

// File: rtl/pfc_apb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_apb_slave #(
   parameter int ADDR_W = 12
) (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [15:0]         rdata,
   output logic [pfc_pkg::REG_CNT-1:0] hitVec,
   output logic                     wrCommit,
   output logic                     pready,
   output logic                     pslverr,
   output logic [31:0]              prdata
);
   import pfc_pkg::*;

   logic        pready_q;
   logic        pready_d;
   logic        pslverr_q;
   logic        pslverr_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;

   // Address decode
   always_comb begin
      hitVec              = '0;
      hitVec[HIT_PA_FUNC] = (paddr[ADDR_W-1:2] == IDX_PA_FUNC[ADDR_W-3:0]);
      hitVec[HIT_PA_DIR]  = (paddr[ADDR_W-1:2] == IDX_PA_DIR[ADDR_W-3:0]);
      hitVec[HIT_PB_HI]   = (paddr[ADDR_W-1:2] == IDX_PB_FUNC_HI[ADDR_W-3:0]);
      hitVec[HIT_PB_DIR]  = (paddr[ADDR_W-1:2] == IDX_PB_DIR[ADDR_W-3:0]);
      hitVec[HIT_PB_LO]   = (paddr[ADDR_W-1:2] == IDX_PB_FUNC_LO[ADDR_W-3:0]);
   end

   // One wait state, then answer
   always_comb begin
      pready_d  = psel && penable && !pready_q;
      pslverr_d = pready_d && (hitVec == '0);
      prdata_d  = prdata_q;
      if (pready_d) begin
         prdata_d = (!pwrite && hitVec != '0) ? {16'h0000, rdata} : 32'h00000000;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   assign wrCommit = psel && penable && pready_q && pwrite && (hitVec != '0);
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign prdata   = prdata_q;
endmodule
`default_nettype wire

// File: rtl/pfc_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_pin_cell #(
   parameter bit HAS_GPIO = 1'b1,
   parameter bit ALT_OUT  = 1'b0,
   parameter bit ALT_IN   = 1'b0,
   parameter bit INV      = 1'b0
) (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic funcBit,
   input  wire logic dirBit,
   input  wire logic gpioOut,
   input  wire logic altOut,
   input  wire logic altOe,
   input  wire logic padIn,
   output logic      padOut,
   output logic      padOe,
   output logic      altIn,
   output logic      gpioIn
);
   localparam bit RST_OE = !HAS_GPIO || INV;

   logic altActive;
   logic padOut_q;
   logic padOut_d;
   logic padOe_q;
   logic padOe_d;
   logic altIn_q;
   logic altIn_d;
   logic gpioIn_q;
   logic gpioIn_d;

   always_comb begin
      altActive = funcBit ^ INV;
      padOut_d  = gpioOut;
      padOe_d   = 1'b0;
      altIn_d   = 1'b0;
      gpioIn_d  = 1'b0;
      if (!HAS_GPIO) begin
         // Fixed output pin choosing between two sources
         padOe_d  = 1'b1;
         padOut_d = altActive ? altOut : gpioOut;
      end else if (altActive) begin
         // Direction bit has no say here
         padOe_d  = ALT_OUT ? altOe : 1'b0;
         padOut_d = ALT_OUT ? altOut : 1'b0;
         altIn_d  = ALT_IN ? padIn : 1'b0;
      end else begin
         padOe_d  = dirBit;
         gpioIn_d = padIn;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         padOut_q <= 1'b0;
         padOe_q  <= RST_OE;
         altIn_q  <= 1'b0;
         gpioIn_q <= 1'b0;
      end else begin
         padOut_q <= padOut_d;
         padOe_q  <= padOe_d;
         altIn_q  <= altIn_d;
         gpioIn_q <= gpioIn_d;
      end
   end

   assign padOut = padOut_q;
   assign padOe  = padOe_q;
   assign altIn  = altIn_q;
   assign gpioIn = gpioIn_q;
endmodule
`default_nettype wire

// File: rtl/pfc_port_a.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_port_a #(
   parameter int ADDR_W = 12
) (
   input  wire logic                         ref_clk,
   input  wire logic                         rst_n,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [ADDR_W-1:0]            paddr,
   input  wire logic [31:0]                  pwdata,
   input  wire logic [3:0]                   pstrb,
   output logic                              pready,
   output logic                              pslverr,
   output logic [31:0]                       prdata,
   input  wire logic [pfc_pkg::PIN_CNT-1:0]  padIn,
   output logic [pfc_pkg::PIN_CNT-1:0]       padOut,
   output logic [pfc_pkg::PIN_CNT-1:0]       padOe,
   input  wire logic [pfc_pkg::PIN_CNT-1:0]  gpioOut,
   output logic [pfc_pkg::PIN_CNT-1:0]       gpioIn,
   input  wire logic                         serial0TransmitData,
   input  wire logic                         serial0TransmitSyncOut,
   input  wire logic                         serial0TransmitSyncOe,
   input  wire logic                         watchdogOverflowOut,
   input  wire logic                         freeTimerCompareAOut,
   input  wire logic                         freeTimerCompareBOut,
   input  wire logic                         peripheralClockOut,
   input  wire logic                         networkGeneralOut,
   output logic                              serial0ReceiveClock,
   output logic                              serial0ReceiveSync,
   output logic                              serial0ReceiveData,
   output logic                              serial0TransmitClock,
   output logic                              serial0TransmitSyncIn,
   output logic                              freeTimerClockIn,
   output logic                              freeTimerCaptureIn,
   output logic                              networkLinkStatusIn,
   output logic                              addressTableSenseIn
);
   import pfc_pkg::*;

   logic [REG_CNT-1:0] hitVec;
   logic               wrCommit;
   logic [15:0]        rdata;
   logic [15:0]        funcSel_q;
   logic [15:0]        funcSel_d;
   logic [15:0]        dirReg_q;
   logic [15:0]        dirReg_d;
   logic [15:0]        pbHigh_q;
   logic [15:0]        pbHigh_d;
   logic [15:0]        pbDir_q;
   logic [15:0]        pbDir_d;
   logic [15:0]        pbLow_q;
   logic [15:0]        pbLow_d;
   logic [PIN_CNT-1:0] primOut;
   logic [PIN_CNT-1:0] altOut;
   logic [PIN_CNT-1:0] altOe;
   logic [PIN_CNT-1:0] altIn;

   function automatic logic [15:0] mergeWrite(input logic [15:0] old,
                                              input logic [31:0] wdata,
                                              input logic [3:0]  strb,
                                              input logic [15:0] mask);
      logic [15:0] val;
      val       = old;
      if (strb[0]) begin
         val[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
         val[15:8] = wdata[15:8];
      end
      return val & mask;
   endfunction

   pfc_apb_slave #(
      .ADDR_W (ADDR_W)
   ) u_apb (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .rdata    (rdata),
      .hitVec   (hitVec),
      .wrCommit (wrCommit),
      .pready   (pready),
      .pslverr  (pslverr),
      .prdata   (prdata)
   );

   // Register writes, masked per register
   always_comb begin
      funcSel_d = funcSel_q;
      dirReg_d  = dirReg_q;
      pbHigh_d  = pbHigh_q;
      pbDir_d   = pbDir_q;
      pbLow_d   = pbLow_q;
      if (wrCommit) begin
         if (hitVec[HIT_PA_FUNC]) begin
            funcSel_d = mergeWrite(funcSel_q, pwdata, pstrb, PA_FUNC_MASK);
         end
         if (hitVec[HIT_PA_DIR]) begin
            dirReg_d = mergeWrite(dirReg_q, pwdata, pstrb, PA_DIR_MASK);
         end
         if (hitVec[HIT_PB_HI]) begin
            pbHigh_d = mergeWrite(pbHigh_q, pwdata, pstrb, PB_MASK);
         end
         if (hitVec[HIT_PB_DIR]) begin
            pbDir_d = mergeWrite(pbDir_q, pwdata, pstrb, PB_MASK);
         end
         if (hitVec[HIT_PB_LO]) begin
            pbLow_d = mergeWrite(pbLow_q, pwdata, pstrb, PB_MASK);
         end
      end
   end

   // Only the power-on reset clears these
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         funcSel_q <= PA_FUNC_RST;
         dirReg_q  <= PA_DIR_RST;
         pbHigh_q  <= PB_RST;
         pbDir_q   <= PB_RST;
         pbLow_q   <= PB_RST;
      end else begin
         funcSel_q <= funcSel_d;
         dirReg_q  <= dirReg_d;
         pbHigh_q  <= pbHigh_d;
         pbDir_q   <= pbDir_d;
         pbLow_q   <= pbLow_d;
      end
   end

   // Read data
   always_comb begin
      rdata = 16'h0000;
      case (1'b1)
         hitVec[HIT_PA_FUNC]: rdata = funcSel_q & PA_FUNC_MASK;
         hitVec[HIT_PA_DIR]:  rdata = dirReg_q & PA_DIR_MASK;
         hitVec[HIT_PB_HI]:   rdata = pbHigh_q;
         hitVec[HIT_PB_DIR]:  rdata = pbDir_q;
         hitVec[HIT_PB_LO]:   rdata = pbLow_q;
         default:             rdata = 16'h0000;
      endcase
   end

   // Peripheral sources per pin
   always_comb begin
      primOut                = gpioOut;
      primOut[PIN_PCLK]      = peripheralClockOut;
      altOut                 = '0;
      altOe                  = PIN_ALT_OUT;
      altOut[PIN_S0_TXDATA]  = serial0TransmitData;
      altOut[PIN_S0_TXSYNC]  = serial0TransmitSyncOut;
      altOe[PIN_S0_TXSYNC]   = serial0TransmitSyncOe;
      altOut[PIN_WDOG]       = watchdogOverflowOut;
      altOut[PIN_FT_CMPA]    = freeTimerCompareAOut;
      altOut[PIN_PCLK]       = freeTimerCompareBOut;
      altOut[PIN_NET_OUT]    = networkGeneralOut;
   end

   // One cell per pin, each on its own select and direction bit
   for (genvar i = 0; i < PIN_CNT; i++) begin : g_pin
      pfc_pin_cell #(
         .HAS_GPIO (PIN_GPIO[i]),
         .ALT_OUT  (PIN_ALT_OUT[i]),
         .ALT_IN   (PIN_ALT_IN[i]),
         .INV      (PIN_INV[i])
      ) u_cell (
         .ref_clk (ref_clk),
         .rst_n   (rst_n),
         .funcBit (funcSel_q[i]),
         .dirBit  (dirReg_q[i]),
         .gpioOut (primOut[i]),
         .altOut  (altOut[i]),
         .altOe   (altOe[i]),
         .padIn   (padIn[i]),
         .padOut  (padOut[i]),
         .padOe   (padOe[i]),
         .altIn   (altIn[i]),
         .gpioIn  (gpioIn[i])
      );
   end

   assign serial0ReceiveClock   = altIn[PIN_S0_RXCLK];
   assign serial0ReceiveSync    = altIn[PIN_S0_RXSYNC];
   assign serial0ReceiveData    = altIn[PIN_S0_RXDATA];
   assign serial0TransmitClock  = altIn[PIN_S0_TXCLK];
   assign serial0TransmitSyncIn = altIn[PIN_S0_TXSYNC];
   assign freeTimerClockIn      = altIn[PIN_FT_CLK];
   assign freeTimerCaptureIn    = altIn[PIN_FT_CAP];
   assign networkLinkStatusIn   = altIn[PIN_NET_LINK];
   assign addressTableSenseIn   = altIn[PIN_NET_SENSE];

   // Checks
   logic seen_q;
   logic seen_d;

   always_comb begin
      seen_d = 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_q <= 1'b0;
      end else begin
         seen_q <= seen_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   // Skip the release edge, where pins still show reset levels
   default disable iff (!rst_n || !seen_q);

   sequence sFuncWrite;
      psel && penable && pready && pwrite && hitVec[HIT_PA_FUNC] && pstrb[1:0] == 2'b11;
   endsequence

   sequence sDirWrite;
      psel && penable && pready && pwrite && hitVec[HIT_PA_DIR] && pstrb[1:0] == 2'b11;
   endsequence

   sequence sFuncRead;
      psel && penable && pready && !pwrite && hitVec[HIT_PA_FUNC];
   endsequence

   AST_RESET_CLEAR: assert property (disable iff (!rst_n)
      !seen_q |-> funcSel_q == 16'h0000 && dirReg_q == 16'h0000 && padOe == 14'h0088)
      else $error("registers not clear after power-on reset");
   AST_FUNC_WRITE: assert property (
      sFuncWrite |=> funcSel_q == ($past(pwdata[15:0]) & 16'h3FFF))
      else $error("function select write not stored");
   AST_FUNC_RSV_READ: assert property (
      sFuncRead |-> prdata[31:14] == '0)
      else $error("function select reserved bits read nonzero");
   AST_DIR_WRITE: assert property (
      sDirWrite |=> dirReg_q == ($past(pwdata[15:0]) & 16'h3FF7))
      else $error("direction write not stored with mask");
   AST_DIR_RSV: assert property (
      dirReg_q[15:14] == 2'b00 && dirReg_q[3] == 1'b0)
      else $error("direction reserved bits set");
   AST_SER_RX_IN: assert property (
      funcSel_q[13] |=> serial0ReceiveClock == $past(padIn[13]))
      else $error("serial receive clock not routed");
   AST_SER_RX_SYNC: assert property (
      funcSel_q[12] |=> serial0ReceiveSync == $past(padIn[12]) && !padOe[12])
      else $error("serial receive sync not routed");
   AST_SER_RX_OFF: assert property (
      !funcSel_q[11] |=> !serial0ReceiveData && !padOe[11] == !$past(dirReg_q[11]))
      else $error("serial receive data leaks in general mode");
   AST_SER_TX_SYNC: assert property (
      funcSel_q[9] |=> padOe[9] == $past(serial0TransmitSyncOe)
         && padOut[9] == $past(serial0TransmitSyncOut))
      else $error("transmit sync pin not driven by serial unit");
   AST_SER_TX_DATA: assert property (
      funcSel_q[8] && !dirReg_q[8] |=> padOe[8] && padOut[8] == $past(serial0TransmitData))
      else $error("direction bit affects peripheral pin");
   AST_DIR_IGNORED: assert property (
      funcSel_q[13] && dirReg_q[13] |=> !padOe[13] && !gpioIn[13])
      else $error("direction bit drives a peripheral input pin");
   AST_WDOG: assert property (
      !funcSel_q[7] |=> padOe[7] && padOut[7] == $past(watchdogOverflowOut))
      else $error("watchdog overflow not on pin 7");
   AST_WDOG_GPIO: assert property (
      funcSel_q[7] |=> padOe[7] == $past(dirReg_q[7]))
      else $error("pin 7 general mode wrong");
   AST_TIMER_IN: assert property (
      funcSel_q[6] |=> freeTimerClockIn == $past(padIn[6]))
      else $error("timer clock input not routed");
   AST_TIMER_CAP: assert property (
      funcSel_q[5] |=> freeTimerCaptureIn == $past(padIn[5]))
      else $error("timer capture input not routed");
   AST_TIMER_CMPA: assert property (
      funcSel_q[4] |=> padOe[4] && padOut[4] == $past(freeTimerCompareAOut))
      else $error("compare A not on pin 4");
   AST_PIN3: assert property (
      1'b1 |=> padOe[3] && padOut[3] == ($past(funcSel_q[3]) ? $past(freeTimerCompareBOut)
         : $past(peripheralClockOut)))
      else $error("pin 3 source wrong");
   AST_NET: assert property (
      funcSel_q[1] && funcSel_q[2] |=> padOe[1] && padOut[1] == $past(networkGeneralOut)
         && networkLinkStatusIn == $past(padIn[2]) && !padOe[2])
      else $error("network pins not routed");
   AST_GPIO_OUT: assert property (
      !funcSel_q[4] && dirReg_q[4] |=> padOe[4] && padOut[4] == $past(gpioOut[4]))
      else $error("general output not driven");
   AST_GPIO_IN: assert property (
      !funcSel_q[0] && !dirReg_q[0] |=> !padOe[0] && gpioIn[0] == $past(padIn[0])
         && !addressTableSenseIn)
      else $error("general input wrong");
endmodule
`default_nettype wire

// File: tb/pfc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_far_model (
   input  wire logic        ref_clk,
   input  wire logic [13:0] padOut,
   input  wire logic [13:0] padOe,
   output logic [13:0]      padIn,
   output logic [13:0]      gpioOut,
   output logic [7:0]       periphOut
);
   logic [13:0] extDrv;

   // Driven pins show the device level, others an outside level
   assign padIn = (padOe & padOut) | (~padOe & extDrv);

   initial begin
      extDrv    = 14'h0000;
      gpioOut   = 14'h0000;
      periphOut = 8'h00;
   end

   // Outside world and peripherals change every cycle
   always @(posedge ref_clk) begin
      extDrv    <= ~extDrv ^ (14'($urandom) & 14'h2AAA);
      gpioOut   <= 14'($urandom);
      periphOut <= 8'($urandom);
   end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin samplesChecked++; if ((a) !== (b)) fail(m); end
module tb_top;
   import pfc_pkg::*;
   logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [13:0] padIn, padOut, padOe, gpioOut, gpioIn, sel, eOe, eOut, eGin, eAlt;
   logic [7:0]  pOut;
   logic        serial0ReceiveClock, serial0ReceiveSync, serial0ReceiveData;
   logic        serial0TransmitClock, serial0TransmitSyncIn, freeTimerClockIn;
   logic        freeTimerCaptureIn, networkLinkStatusIn, addressTableSenseIn;
   logic [15:0] mdl [5]   = '{default: 16'h0000};
   logic [15:0] wmask [5] = '{16'h3FFF, 16'h3FF7, 16'hFFFF, 16'hFFFF, 16'hFFFF};
   logic [31:0] idx [5]   = '{IDX_PA_FUNC, IDX_PA_DIR, IDX_PB_FUNC_HI, IDX_PB_DIR, IDX_PB_FUNC_LO};
   int          nErrors = 0;
   int          samplesChecked = 0;
   int          k;
   bit          chkOn = 0;

   pfc_port_a #(.ADDR_W(12)) u_dut (
      .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr,
      .prdata, .padIn, .padOut, .padOe, .gpioOut, .gpioIn,
      .serial0TransmitData(pOut[0]), .serial0TransmitSyncOut(pOut[1]),
      .serial0TransmitSyncOe(pOut[2]), .watchdogOverflowOut(pOut[3]),
      .freeTimerCompareAOut(pOut[4]), .freeTimerCompareBOut(pOut[5]),
      .peripheralClockOut(pOut[6]), .networkGeneralOut(pOut[7]),
      .serial0ReceiveClock, .serial0ReceiveSync, .serial0ReceiveData, .serial0TransmitClock,
      .serial0TransmitSyncIn, .freeTimerClockIn, .freeTimerCaptureIn, .networkLinkStatusIn,
      .addressTableSenseIn);

   pfc_far_model u_far (.ref_clk, .padOut, .padOe, .padIn, .gpioOut, .periphOut(pOut));

   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;

   task automatic fail(input string m);
      nErrors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
   endtask

   task automatic closeOut();
      if (nErrors == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Expected pin state for the coming edge
   always @(negedge ref_clk) begin
      sel = mdl[0][13:0] ^ 14'h0080;
      sel[3] = 1'b1;
      eOe = mdl[1][13:0] & ~sel;
      eOut = gpioOut & ~sel;
      eGin = padIn & ~sel;
      eAlt = padIn & sel & 14'h3E65;
      {eOe[3], eOut[3]} = {1'b1, mdl[0][3] ? pOut[5] : pOut[6]};
      if (sel[7]) {eOe[7], eOut[7]} = {1'b1, pOut[3]};
      if (sel[8]) {eOe[8], eOut[8]} = {1'b1, pOut[0]};
      if (sel[9]) {eOe[9], eOut[9]} = {pOut[2], pOut[1]};
      if (sel[4]) {eOe[4], eOut[4]} = {1'b1, pOut[4]};
      if (sel[1]) {eOe[1], eOut[1]} = {1'b1, pOut[7]};
   end

   always @(posedge ref_clk) begin
      if (chkOn && rst_n) begin
         #1;
         `CHK(padOe, eOe, "pin enable")
         `CHK(padOut & eOe, eOut & eOe, "pin drive")
         `CHK(gpioIn, eGin, "general input")
         `CHK({serial0ReceiveClock, serial0ReceiveSync, serial0ReceiveData, serial0TransmitClock,
               serial0TransmitSyncIn, 2'b00, freeTimerClockIn, freeTimerCaptureIn, 2'b00,
               networkLinkStatusIn, 1'b0, addressTableSenseIn}, eAlt, "peripheral input")
      end
   end

   // One APB transfer; k < 0 means the unmapped address ua
   task automatic apb(input int k, input bit wr, input logic [31:0] d, input logic [3:0] s,
                      input logic [11:0] ua = 12'h204);
      logic [31:0] rd;
      logic        err;
      int          n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= (k < 0) ? ua : 12'(idx[k] << 2);
      pwdata <= d;
      pstrb <= s;
      @(posedge ref_clk) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fail("no answer");
         closeOut();
      end else begin
         `CHK(err, k < 0, "error flag")
         if (k < 0 && !wr) `CHK(rd, 32'h0, "unmapped read data")
         if (k >= 0 && wr) begin
            for (int b = 0; b < 2; b++) begin
               if (s[b]) mdl[k][8*b+:8] = d[8*b+:8] & wmask[k][8*b+:8];
            end
         end
         if (k >= 0 && !wr) `CHK(rd, {16'h0000, mdl[k]}, "read data")
         @(posedge ref_clk);
      end
   endtask

   task automatic startUp();
      rst_n <= 1'b1;
      @(posedge ref_clk);
      @(negedge ref_clk) chkOn = 1;
      @(posedge ref_clk);
      for (int r = 0; r < 5; r++) apb(r, 1'b0, 32'h0, 4'hF);
   endtask

   initial begin
      void'($urandom(32'he056));
      {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      repeat (20) @(posedge ref_clk);
      startUp();
      // Each pin alone in its peripheral use, then all, then none; pin 7 drives until set
      for (int i = 0; i < 16; i++) begin
         apb(1, 1'b1, $urandom, 4'h3);
         apb(0, 1'b1, (i < 14) ? 32'(1 << i) : ((i == 14) ? 32'h3FFF : 32'h0), 4'h3);
         repeat (4) @(posedge ref_clk);
         apb(0, 1'b0, 32'h0, 4'hF);
         apb(1, 1'b0, 32'h0, 4'hF);
      end
      // Random lanes, reserved bits set on purpose, unmapped places
      for (int i = 0; i < 60; i++) begin
         k = int'($urandom_range(5)) - 1;
         apb(k, 1'($urandom), $urandom, 4'($urandom), $urandom_range(1) ? 12'h204 : 12'hFFC);
      end
      for (int r = 0; r < 5; r++) apb(r, 1'b0, 32'h0, 4'hF);
      // Reset in mid-run clears every register
      @(negedge ref_clk) chkOn = 0;
      @(posedge ref_clk) rst_n <= 1'b0;
      foreach (mdl[r]) mdl[r] = 16'h0000;
      repeat (3) @(posedge ref_clk);
      startUp();
      repeat (5) @(posedge ref_clk);
      closeOut();
   end
endmodule
`default_nettype wire
